// File: design/tcc_pkg.sv
// Package for the channel 2/3 capture/compare configuration block
package tcc_pkg;

  // ==========================================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h1C;
  localparam logic [7:0] OFF_CHEN = 8'h20;
  localparam logic [7:0] OFF_CV2 = 8'h3C;
  localparam logic [7:0] OFF_CV3 = 8'h40;
  localparam logic [7:0] OFF_PROTECTION_LEVEL = 8'h44;
  localparam logic [7:0] OFF_STAT = 8'h48;

  // ==========================================================================
  // Reset values and field positions
  localparam logic [15:0] CTRL_RESET = 16'h0000;
  localparam logic [15:0] CHEN_RESET = 16'h0000;
  localparam logic [15:0] CHEN_MASK = 16'h3B00;
  localparam logic [1:0] PROTECTION_LEVEL_RESET = 2'h0;
  localparam int CH_BYTE_W = 8;
  localparam int CHEN_CHAN2_ENABLE_BIT = 8;
  localparam int CHEN_CH2P = 9;
  localparam int CHEN_CH2NP = 11;
  localparam int CHEN_CHAN3_ENABLE_BIT = 12;
  localparam int CHEN_CH3P = 13;
  localparam int CNT_W = 16;

  // ==========================================================================
  // Encodings
  localparam logic [2:0] MODE_TIMING = 3'h0;
  localparam logic [2:0] MODE_SET = 3'h1;
  localparam logic [2:0] MODE_CLEAR = 3'h2;
  localparam logic [2:0] MODE_TOGGLE = 3'h3;
  localparam logic [2:0] MODE_LOW = 3'h4;
  localparam logic [2:0] MODE_HIGH = 3'h5;
  localparam logic [2:0] MODE_PWM0 = 3'h6;
  localparam logic [2:0] MODE_PWM1 = 3'h7;
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_TRIG_IN = 2'h3;
  localparam logic [1:0] PROTECTION_LEVEL_LOCKED = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic clear_en;
    logic [2:0] mode;
    logic shadow_en;
    logic fast_en;
    logic [1:0] dir;
  } tcc_chan_cfg_t;

  typedef struct packed {
    logic [CNT_W-1:0] counter_value;
    logic count_down;
    logic update_event;
    logic trigger_edge;
    logic filtered_ext_trigger;
  } tcc_tmr_in_t;

endpackage

// File: design/tcc_shadow.sv
// Compare value holding register with optional shadow transfer on update
`timescale 1ns/1ps
module tcc_shadow import tcc_pkg::*; #(
  parameter int W = CNT_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Software write
  input wire logic wr_en,
  input wire logic [W-1:0] wr_data,
  // Control
  input wire logic shadow_en,
  input wire logic update_event,
  // Values
  output logic [W-1:0] preload,
  output logic [W-1:0] active
);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      preload <= '0;
      active <= '0;
    end else if (ce) begin
      if (wr_en) begin
        preload <= wr_data;
      end
      if (!shadow_en && wr_en) begin
        active <= wr_data;
      end else if (shadow_en && update_event) begin
        active <= preload;
      end
    end
  end

endmodule

// File: design/tcc_chan.sv
// Output reference generator for one compare channel
`timescale 1ns/1ps
module tcc_chan import tcc_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // Configuration
  input wire tcc_chan_cfg_t cfg,
  input wire logic [CNT_W-1:0] compare_value,
  input wire logic pol,
  input wire logic npol,
  // Timer kernel
  input wire tcc_tmr_in_t tmr,
  // Outputs
  output logic ref_level,
  output logic out_main,
  output logic out_comp
);

  logic match_q;
  logic pwm_q;
  logic was_timing;
  logic next_ref;

  wire match = tmr.counter_value == compare_value;
  wire match_hit = match & ~match_q;
  wire is_pwm = cfg.mode[2] & cfg.mode[1];
  // Down counting: high unless counter is above compare
  wire pwm0_level = tmr.count_down ? (tmr.counter_value <= compare_value)
                                   : (tmr.counter_value < compare_value);
  wire pwm_level = cfg.mode[0] ? ~pwm0_level : pwm0_level;
  // Level the output takes just after a compare match
  wire fast_level = tmr.count_down ^ cfg.mode[0];
  wire fast_hit = is_pwm & cfg.fast_en & tmr.trigger_edge;
  // Only a fresh entry from timing mode or a comparison change moves the level
  wire pwm_move = was_timing | (pwm_level != pwm_q);

  always_comb begin
    next_ref = ref_level;
    if (cfg.dir == DIR_OUTPUT) begin
      case (cfg.mode)
        MODE_TIMING: next_ref = ref_level;
        MODE_SET: next_ref = match_hit ? 1'b1 : ref_level;
        MODE_CLEAR: next_ref = match_hit ? 1'b0 : ref_level;
        MODE_TOGGLE: next_ref = match_hit ? ~ref_level : ref_level;
        MODE_LOW: next_ref = 1'b0;
        MODE_HIGH: next_ref = 1'b1;
        MODE_PWM0, MODE_PWM1: next_ref = pwm_move ? pwm_level : ref_level;
        default: next_ref = ref_level;
      endcase
      if (fast_hit) begin
        next_ref = fast_level;
      end
      if (cfg.clear_en && tmr.filtered_ext_trigger) begin
        next_ref = 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_q <= 1'b0;
      pwm_q <= 1'b0;
      was_timing <= 1'b1;
      ref_level <= 1'b0;
      out_main <= 1'b0;
      out_comp <= 1'b0;
    end else if (ce) begin
      match_q <= match;
      pwm_q <= pwm_level;
      was_timing <= cfg.mode == MODE_TIMING;
      ref_level <= next_ref;
      out_main <= next_ref ^ pol;
      out_comp <= ~next_ref ^ npol;
    end
  end

endmodule

// File: design/tcc_ctrl.sv
// Channel 2/3 capture/compare configuration with AXI4-Lite register slave
//
// Contract
// - Channel 3 direction bits 9:8: 00 output, else input from ch3, ch2 or trigger.
// - Direction field writes take effect only while that channel is disabled.
// - Clear enable with external trigger high drives channel 2 reference low.
// - Timing mode 000 keeps the reference steady whatever the comparison.
// - Mode 001 sets the reference high on counter equal compare value.
// - Mode 010 clears the reference on counter equal compare value.
// - Mode 011 toggles the reference on every counter match.
// - Mode 100 forces low, mode 101 forces high.
// - PWM mode 0: up high below compare; down low above compare.
// - PWM mode 1: inverse levels of PWM mode 0.
// - PWM level moves only on entry from timing or a comparison change.
// - Compare mode writes blocked when protection is 11 and channel is output.
// - High reference is active; outputs apply their polarity bits.
// - Shadow bit 3 makes written compare values go through a shadow copy.
// - With shadowing, the active compare value loads only at update events.
// - Channel 3 has clear, mode, shadow, fast bits at 15, 14:12, 11, 10.
// - Fast enable in PWM treats a trigger edge as a compare match.
// - Channel 2 direction bits 1:0: input from ch2, ch3 or trigger.
// - Control register at 0x1C, reset value 0x0000.
// - Control register accepts half-word and word accesses.
//
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
module tcc_ctrl import tcc_pkg::*; #(
  parameter int AW = 8,
  parameter int CW = CNT_W
) (
  // Clock, reset and clock enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic ce,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic [2:0] awprot,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  input wire logic [2:0] arprot,
  // AXI4-Lite read data
  input wire logic rvalid_unused_tie,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Timer kernel
  input wire tcc_tmr_in_t tmr,
  // Compare outputs
  output logic chan2_output_reference,
  output logic chan3_output_reference,
  output logic chan2_out,
  output logic chan2_out_comp,
  output logic chan3_out,
  // Capture configuration
  output logic [1:0] chan2_capture_source,
  output logic [1:0] chan3_capture_source,
  output logic [3:0] chan2_capture_filter,
  output logic [3:0] chan3_capture_filter,
  output logic [1:0] chan2_capture_prescale,
  output logic [1:0] chan3_capture_prescale,
  output logic trigger_capture_used,
  // Active compare values
  output logic [CW-1:0] chan2_compare_value,
  output logic [CW-1:0] chan3_compare_value
);

  // ==========================================================================
  // Parameter checks
  if (CW != CNT_W) begin : g_bad_cw
    $error("Compare width must match the counter carrier width");
  end
  if (AW < 8 || AW > 32) begin : g_bad_aw
    $error("Address width must be between 8 and 32");
  end

  // ==========================================================================
  // Decoding helpers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
                                          input logic [3:0] strb);
    logic [15:0] res;
    res = old;
    if (strb[0]) begin
      res[7:0] = data[7:0];
    end
    if (strb[1]) begin
      res[15:8] = data[15:8];
    end
    return res;
  endfunction

  // Field protection for one channel byte of the control register
  function automatic tcc_chan_cfg_t guard_cfg(input tcc_chan_cfg_t old, input tcc_chan_cfg_t upd,
                                              input logic enabled, input logic [1:0] protection_level);
    tcc_chan_cfg_t res;
    res = upd;
    if (enabled) begin
      res.dir = old.dir;
    end
    if (protection_level == PROTECTION_LEVEL_LOCKED && old.dir == DIR_OUTPUT) begin
      res.mode = old.mode;
      res.shadow_en = old.shadow_en;
    end
    return res;
  endfunction

  function automatic logic [AW-1:0] word_addr(input logic [AW-1:0] a);
    return {a[AW-1:2], 2'b00};
  endfunction

  // ==========================================================================
  // Register state
  logic [15:0] ctrl;
  logic [15:0] chen;
  logic [1:0] protection_level_level;
  logic aw_held;
  logic [AW-1:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  tcc_chan_cfg_t chan_cfg [2];
  logic [CW-1:0] cv_pre [2];
  logic [CW-1:0] cv_act [2];
  logic cv_wr [2];
  logic ch_en [2];
  logic ch_pol [2];
  logic ch_npol [2];
  logic ch_ref [2];
  logic ch_out [2];
  logic ch_comp [2];

  // ==========================================================================
  // Write path: address and data are taken in either order
  wire do_write = aw_held & w_held & ~bvalid;
  wire [AW-1:0] wa = word_addr(aw_addr);
  wire hit_ctrl_w = wa == AW'(OFF_CTRL);
  wire hit_chen_w = wa == AW'(OFF_CHEN);
  wire hit_cv2_w = wa == AW'(OFF_CV2);
  wire hit_cv3_w = wa == AW'(OFF_CV3);
  wire hit_protection_level_w = wa == AW'(OFF_PROTECTION_LEVEL);
  wire hit_stat_w = wa == AW'(OFF_STAT);
  wire write_mapped = hit_ctrl_w | hit_chen_w | hit_cv2_w | hit_cv3_w | hit_protection_level_w | hit_stat_w;

  // Byte strobes let a half-word store touch only the low half
  wire [15:0] ctrl_merged = merge16(ctrl, w_data, w_strb);
  wire [15:0] chen_merged = merge16(chen, w_data, w_strb) & CHEN_MASK;
  wire [15:0] cv_merged2 = merge16(16'(cv_pre[0]), w_data, w_strb);
  wire [15:0] cv_merged3 = merge16(16'(cv_pre[1]), w_data, w_strb);
  wire tcc_chan_cfg_t cfg2_new = guard_cfg(chan_cfg[0], tcc_chan_cfg_t'(ctrl_merged[7:0]), ch_en[0], protection_level_level);
  wire tcc_chan_cfg_t cfg3_new = guard_cfg(chan_cfg[1], tcc_chan_cfg_t'(ctrl_merged[15:8]), ch_en[1], protection_level_level);

  // No new address or data is taken while a response still waits
  assign awready = ce & ~aw_held & ~bvalid;
  assign wready = ce & ~w_held & ~bvalid;
  assign cv_wr[0] = do_write & hit_cv2_w;
  assign cv_wr[1] = do_write & hit_cv3_w;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end else if (ce) begin
      if (awvalid && awready) begin
        aw_held <= 1'b1;
        aw_addr <= awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (wvalid && wready) begin
        w_held <= 1'b1;
        w_data <= wdata;
        w_strb <= wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= write_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= CTRL_RESET;
    end else if (ce && do_write && hit_ctrl_w) begin
      ctrl <= {cfg3_new, cfg2_new};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chen <= CHEN_RESET;
    end else if (ce && do_write && hit_chen_w) begin
      chen <= chen_merged;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      protection_level_level <= PROTECTION_LEVEL_RESET;
    end else if (ce && do_write && hit_protection_level_w && w_strb[0]) begin
      protection_level_level <= w_data[1:0];
    end
  end

  // Each channel owns one byte of the control register
  assign chan_cfg[0] = tcc_chan_cfg_t'(ctrl[CH_BYTE_W-1:0]);
  assign chan_cfg[1] = tcc_chan_cfg_t'(ctrl[2*CH_BYTE_W-1:CH_BYTE_W]);
  assign ch_en[0] = chen[CHEN_CHAN2_ENABLE_BIT];
  assign ch_en[1] = chen[CHEN_CHAN3_ENABLE_BIT];
  assign ch_pol[0] = chen[CHEN_CH2P];
  assign ch_pol[1] = chen[CHEN_CH3P];
  assign ch_npol[0] = chen[CHEN_CH2NP];
  // Channel 3 has no complementary pin
  assign ch_npol[1] = 1'b0;

  // ==========================================================================
  // Channels
  for (genvar i = 0; i < 2; i++) begin : g_chan
    tcc_shadow #(
      .W(CW)
    ) u_shadow (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .wr_en(cv_wr[i]),
      .wr_data(i == 0 ? CW'(cv_merged2) : CW'(cv_merged3)),
      .shadow_en(chan_cfg[i].shadow_en),
      .update_event(tmr.update_event),
      .preload(cv_pre[i]),
      .active(cv_act[i])
    );

    tcc_chan u_chan (
      .aclk(aclk),
      .aresetn(aresetn),
      .ce(ce),
      .cfg(chan_cfg[i]),
      .compare_value(cv_act[i]),
      .pol(ch_pol[i]),
      .npol(ch_npol[i]),
      .tmr(tmr),
      .ref_level(ch_ref[i]),
      .out_main(ch_out[i]),
      .out_comp(ch_comp[i])
    );
  end

  assign chan2_output_reference = ch_ref[0];
  assign chan3_output_reference = ch_ref[1];
  assign chan2_out = ch_out[0];
  assign chan2_out_comp = ch_comp[0];
  assign chan3_out = ch_out[1];
  assign chan2_compare_value = cv_act[0];
  assign chan3_compare_value = cv_act[1];

  // ==========================================================================
  // Capture view of the same bits; zero while the channel drives an output
  wire ch2_in = chan_cfg[0].dir != DIR_OUTPUT;
  wire ch3_in = chan_cfg[1].dir != DIR_OUTPUT;
  assign chan2_capture_source = chan_cfg[0].dir;
  assign chan3_capture_source = chan_cfg[1].dir;
  assign chan2_capture_filter = ch2_in ? ctrl[7:4] : 4'h0;
  assign chan3_capture_filter = ch3_in ? ctrl[15:12] : 4'h0;
  assign chan2_capture_prescale = ch2_in ? ctrl[3:2] : 2'h0;
  assign chan3_capture_prescale = ch3_in ? ctrl[11:10] : 2'h0;
  // Tells the slave controller that a trigger selection is needed
  assign trigger_capture_used = (chan_cfg[0].dir == DIR_TRIG_IN) | (chan_cfg[1].dir == DIR_TRIG_IN);

  // ==========================================================================
  // Read path
  wire [AW-1:0] ra = word_addr(araddr);
  wire [31:0] stat_word = {27'h0, ch_out[1], ch_comp[0], ch_out[0], ch_ref[1], ch_ref[0]};
  wire hit_ctrl_r = ra == AW'(OFF_CTRL);
  wire hit_chen_r = ra == AW'(OFF_CHEN);
  wire hit_cv2_r = ra == AW'(OFF_CV2);
  wire hit_cv3_r = ra == AW'(OFF_CV3);
  wire hit_protection_level_r = ra == AW'(OFF_PROTECTION_LEVEL);
  wire hit_stat_r = ra == AW'(OFF_STAT);
  wire read_mapped = hit_ctrl_r | hit_chen_r | hit_cv2_r | hit_cv3_r | hit_protection_level_r | hit_stat_r;
  wire [31:0] read_word = hit_ctrl_r ? {16'h0000, ctrl} :
                          hit_chen_r ? {16'h0000, chen} :
                          hit_cv2_r ? 32'(cv_pre[0]) :
                          hit_cv3_r ? 32'(cv_pre[1]) :
                          hit_protection_level_r ? {30'h0, protection_level_level} :
                          hit_stat_r ? stat_word : 32'h00000000;

  assign arready = ce & ~rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
    end else if (ce) begin
      if (arvalid && arready) begin
        rvalid <= 1'b1;
      end else if (rvalid && rready) begin
        rvalid <= 1'b0;
      end
    end
  end

  // Data only loads on acceptance, so it stands while rvalid waits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
    end else if (ce && arvalid && arready) begin
      rdata <= read_word;
      rresp <= read_mapped ? RESP_OKAY : RESP_SLVERR;
    end
  end

endmodule

// File: verif/tcc_ctrl_sva.sv
// Assertion checker for the channel 2/3 compare configuration block
`timescale 1ns/1ps
module tcc_ctrl_chk import tcc_pkg::*; #(
  parameter int AW = 8,
  parameter int CW = CNT_W
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic awvalid,
  input wire logic awready,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic [1:0] bresp,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic [31:0] rdata,
  // Timer and channel outputs
  input wire tcc_tmr_in_t tmr,
  input wire logic chan2_output_reference,
  input wire logic [1:0] chan2_capture_source,
  input wire logic [1:0] chan3_capture_source,
  input wire logic [3:0] chan2_capture_filter,
  input wire logic [1:0] chan2_capture_prescale,
  input wire logic trigger_capture_used,
  input wire logic [CW-1:0] chan2_compare_value
);
  // ==========================================================================
  // Properties
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  wr_resp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp)) else $error("bresp dropped early");
  rd_data_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata)) else $error("rdata dropped early");
  rd_block_a: assert property (rvalid |-> !arready) else $error("read taken while busy");
  wr_block_a: assert property (bvalid |-> !awready && !wready) else $error("write taken while busy");
  wr_latency_a: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid) else $error("late bvalid");
  rd_latency_a: assert property (arvalid && arready |=> rvalid) else $error("late rvalid");
  input_fields_a: assert property (chan2_capture_source == 2'h0 |-> chan2_capture_filter == 4'h0 && chan2_capture_prescale == 2'h0) else $error("filter bits in output mode");
  trig_used_a: assert property (trigger_capture_used == (chan2_capture_source == 2'h3 || chan3_capture_source == 2'h3)) else $error("trigger source flag wrong");
  ref_frozen_a: assert property (chan2_capture_source != 2'h0 |=> $stable(chan2_output_reference)) else $error("reference moved in input mode");
  cv_update_a: assert property ($changed(chan2_compare_value) |-> $past(tmr.update_event) || bvalid || $past(bvalid)) else $error("compare value moved without cause");
  reset_val_a: assert property ($rose(aresetn) |-> chan2_capture_source == 2'h0 && !chan2_output_reference) else $error("bad reset state");
endmodule

bind tcc_ctrl tcc_ctrl_chk #(.AW(AW), .CW(CW)) chk_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready), .bresp(bresp),
  .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready), .rdata(rdata), .tmr(tmr),
  .chan2_output_reference(chan2_output_reference), .chan2_capture_source(chan2_capture_source),
  .chan3_capture_source(chan3_capture_source), .chan2_capture_filter(chan2_capture_filter),
  .chan2_capture_prescale(chan2_capture_prescale), .trigger_capture_used(trigger_capture_used),
  .chan2_compare_value(chan2_compare_value));

// File: verif/tcc_ctrl_tb.sv
// Self-checking bench for the channel 2/3 compare configuration block
`timescale 1ns/1ps
module tcc_ctrl_tb import tcc_pkg::*; ;
  // ==========================================================================
  // Signals
  localparam logic [2:0] MSEQ [7] = '{MODE_HIGH, MODE_TIMING, MODE_CLEAR, MODE_SET, MODE_TOGGLE, MODE_TOGGLE, MODE_LOW};
  localparam logic [6:0] RSEQ = 7'h6A;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic awready, wready, bvalid, arready, rvalid, ref2, ref3, out2, out2n, out3, trig_used;
  logic [1:0] bresp, rresp, src2, src3, psc2, psc3;
  logic [3:0] flt2, flt3;
  logic [31:0] rdata;
  logic [CNT_W-1:0] cv2, cv3;
  tcc_tmr_in_t tmr = '0;
  int num_errors = 0;
  int samples_checked = 0;
  logic [31:0] rq[$];
  logic [1:0] bq[$], rrq[$];
  logic [15:0] seed = 16'h6DA0; // Seed 28064

  initial begin
    forever #20 aclk = ~aclk;
  end

  tcc_ctrl dut_u (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .awvalid(awvalid), .awready(awready),
    .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
    .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
    .arprot(3'h0), .rvalid_unused_tie(1'b0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
    .tmr(tmr), .chan2_output_reference(ref2), .chan3_output_reference(ref3), .chan2_out(out2),
    .chan2_out_comp(out2n), .chan3_out(out3), .chan2_capture_source(src2), .chan3_capture_source(src3),
    .chan2_capture_filter(flt2), .chan3_capture_filter(flt3), .chan2_capture_prescale(psc2),
    .chan3_capture_prescale(psc3), .trigger_capture_used(trig_used), .chan2_compare_value(cv2),
    .chan3_compare_value(cv3));

  // ==========================================================================
  // Tasks
  function automatic logic [15:0] xs(input logic [15:0] x);
    logic [15:0] y;
    y = x ^ (x << 7);
    y = y ^ (y >> 9);
    return y ^ (y << 8);
  endfunction

  // Status word with all three polarity bits clear
  function automatic logic [31:0] st(input logic r2, input logic r3);
    return {27'h0, r3, ~r2, r2, r3, r2};
  endfunction

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge aclk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF,
                    input logic [1:0] r = RESP_OKAY);
    int n;
    @(posedge aclk);
    bq.push_back(r);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1 && n < 40);
    bready <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      print_verdict();
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r = RESP_OKAY);
    int n;
    @(posedge aclk);
    rq.push_back(e);
    rrq.push_back(r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1 && n < 40);
    rready <= 1'b0;
    if (n >= 40) begin
      num_errors++;
      print_verdict();
    end
  endtask

  // Results are matched against the oldest note as they appear
  always @(posedge aclk) begin
    if (bvalid === 1'b1 && bready) check("bresp", 32'(bresp), 32'(bq.pop_front()));
    if (rvalid === 1'b1 && rready) begin
      check("rdata", rdata, rq.pop_front());
      check("rresp", 32'(rresp), 32'(rrq.pop_front()));
    end
  end

  // ==========================================================================
  // Scenarios
  initial begin
    logic [15:0] c;
    logic lv;
    int i;
    int k;
    tick(5);
    aresetn <= 1'b1;
    rd(OFF_CTRL, {16'h0, CTRL_RESET});
    rd(OFF_STAT, st(1'b0, 1'b0));
    wr(8'h50, 32'h1, 4'hF, RESP_SLVERR);
    rd(8'h50, 32'h0, RESP_SLVERR);
    wr(OFF_CV2, 32'h0000_0010);
    wr(OFF_CTRL, 32'hFFFF_0050, 4'h3);
    rd(OFF_CTRL, 32'h0000_0050);
    for (i = 0; i < 7; i++) begin
      wr(OFF_CTRL, {25'h0, MSEQ[i], 4'h0});
      tmr.counter_value <= 16'h000F;
      tick(2);
      tmr.counter_value <= 16'h0010;
      tick(3);
      tmr.counter_value <= 16'h000F;
      rd(OFF_STAT, st(RSEQ[6-i], 1'b0));
      check("pins", 32'({out3, out2n, out2, ref3, ref2}), st(RSEQ[6-i], 1'b0));
    end
    for (k = 0; k < 2; k++) begin
      wr(OFF_CTRL, 32'h0);
      wr(OFF_CTRL, k ? 32'h70 : 32'h60);
      for (i = 0; i < 8; i++) begin
        seed = xs(seed);
        c = 16'h0008 + {12'h0, seed[3:0]};
        tmr.counter_value <= c;
        tmr.count_down <= seed[8];
        tick(2);
        lv = seed[8] ? (c <= 16'h0010) : (c < 16'h0010);
        rd(OFF_STAT, st(lv ^ k[0], 1'b0));
      end
    end
    tmr.counter_value <= 16'h0020;
    tmr.count_down <= 1'b1;
    wr(OFF_CTRL, 32'h0);
    wr(OFF_CTRL, 32'h64);
    rd(OFF_STAT, st(1'b0, 1'b0));
    tmr.trigger_edge <= 1'b1;
    tick(1);
    tmr.trigger_edge <= 1'b0;
    tick(2);
    rd(OFF_STAT, st(1'b1, 1'b0));
    for (k = 0; k < 2; k++) begin
      tmr.filtered_ext_trigger <= k[0];
      wr(OFF_CTRL, 32'h50D0);
      rd(OFF_STAT, st(~k[0], 1'b1));
    end
    tmr.filtered_ext_trigger <= 1'b0;
    wr(OFF_CHEN, 32'h1100);
    wr(OFF_CTRL, 32'h5155);
    rd(OFF_CTRL, 32'h5054);
    wr(OFF_CHEN, 32'h2A00);
    rd(OFF_CHEN, 32'h2A00);
    rd(OFF_STAT, 32'h0000_000B);
    for (k = 1; k < 4; k++) begin
      wr(OFF_CTRL, {16'h0, 4'hC, 2'h2, k[1:0], 4'h9, 2'h1, k[1:0]});
      check("cap2", 32'({src2, flt2, psc2}), 32'({k[1:0], 4'h9, 2'h1}));
      check("cap3", 32'({trig_used, src3, flt3, psc3}), 32'({k == 3, k[1:0], 4'hC, 2'h2}));
    end
    wr(OFF_CTRL, 32'h0008);
    wr(OFF_CV2, 32'h1234);
    rd(OFF_CV2, 32'h1234);
    check("cv2", 32'(cv2), 32'h0010);
    tmr.update_event <= 1'b1;
    tick(1);
    tmr.update_event <= 1'b0;
    tick(1);
    check("cv2", 32'(cv2), 32'h1234);
    wr(OFF_CV3, 32'h0055);
    check("cv3", 32'(cv3), 32'h0055);
    wr(OFF_PROTECTION_LEVEL, 32'h3);
    wr(OFF_CTRL, 32'h0070);
    rd(OFF_CTRL, 32'h0008);
    tick(2);
    print_verdict();
  end
endmodule
